// ===== rtl/rbmc_top.v
// Baseband and RF front-end mode configuration registers behind an AXI4-Lite slave.
//
// Operation
// - High-rate mode runs 625 instead of 250 kbps.
// - Bit 0 of register 0x38 enables high rate.
// - Baseband reset request finishes the mode change.
// - Value 111 hands pins 0-2 to amplifiers.
// - Pins 0,1 high on transmit; pin 2 inverse.
// - Amplifier pins follow RF state, not software.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rbmc_map.vh"
module rbmc_top #(
  parameter RST_CYCLES = `RBMC_SOFT_RST_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rf_tx_active,
  input wire [2:0] gen_gpio_out,
  input wire [2:0] gen_gpio_oe,
  output wire [2:0] gpio_out,
  output wire [2:0] gpio_oe,
  output reg high_rate_active,
  output reg [9:0] over_air_rate_kbps,
  output wire baseband_reset,
  output wire mac_reset,
  output wire power_block_reset,
  output reg [3:0] preamble_valid_threshold,
  output reg [2:0] preamble_detect_threshold,
  output reg [2:0] carrier_sense_threshold,
  output reg [2:0] preamble_count,
  output reg [8:0] power_amp_on_time,
  output reg [8:0] tx_on_time,
  output reg [3:0] rf_stabilize_time,
  output reg [3:0] short_ifs_time
);

  // Stored register contents; reserved bits are not kept and read as zero.
  reg [7:0] amp_on_time_high_and_tick;
  reg [7:0] power_amp_on_time_low;
  reg [4:0] power_amp_on_time_ctrl;
  reg [6:0] tx_on_time_ctrl; // Bit 6 holds the FIFO enable bit, bits 5:0 the rest.
  reg [7:0] tx_stabilize_ifs;
  reg high_rate_enable;
  reg [6:0] preamble_threshold; // Register bits 7:1.
  reg [5:0] carrier_sense_preamble; // Register bits 7:2.
  reg [4:0] front_end_pin_select; // Register bits 4:0.

  // Write channel holding registers; address and data may come in either order.
  reg aw_held;
  reg w_held;
  reg [9:0] wr_idx;
  reg [7:0] wr_byte;
  reg wr_lane0;

  // Soft reset starts, one per circuit block, and their status.
  reg [2:0] rst_start;
  wire [2:0] rst_busy;
  wire [2:0] rst_done;

  // Combined decode results.
  reg wr_hit;
  reg rd_hit;
  reg [7:0] rd_byte;
  wire wr_fire;
  wire [9:0] rd_idx;
  wire ext_amp_sel; // High while the RF state machine owns pins 0 to 2.

  // A store waits for the previous response to be taken, so a stalled bready loses nothing.
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_idx = s_axi_araddr[11:2];
  assign baseband_reset = rst_busy[`RBMC_RST_BB_BIT];
  assign mac_reset = rst_busy[`RBMC_RST_MAC_BIT];
  assign power_block_reset = rst_busy[`RBMC_RST_PWR_BIT];
  assign ext_amp_sel = (front_end_pin_select[2:0] == `RBMC_FE_SEL_EXT);

  // Write address decode; only the index bits matter, low address bits are ignored.
  always @* begin
    case (wr_idx)
      `RBMC_IDX_AMP_TICK, `RBMC_IDX_PA_ON_LOW, `RBMC_IDX_PA_ON_CTRL,
      `RBMC_IDX_TX_ON_CTRL, `RBMC_IDX_SOFT_RST, `RBMC_IDX_TX_STBL,
      `RBMC_IDX_HR_EN, `RBMC_IDX_PREAMBLE, `RBMC_IDX_CS,
      `RBMC_IDX_FE_SEL: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  // Read multiplexer; soft reset bits show whether each pulse is still running.
  always @* begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      `RBMC_IDX_AMP_TICK: begin
        rd_byte = amp_on_time_high_and_tick;
      end
      `RBMC_IDX_PA_ON_LOW: begin
        rd_byte = power_amp_on_time_low;
      end
      `RBMC_IDX_PA_ON_CTRL: begin
        rd_byte = {3'h0, power_amp_on_time_ctrl};
      end
      `RBMC_IDX_TX_ON_CTRL: begin
        rd_byte = {tx_on_time_ctrl[6], 1'b0, tx_on_time_ctrl[5:0]};
      end
      `RBMC_IDX_SOFT_RST: begin
        rd_byte = {5'h00, rst_busy};
      end
      `RBMC_IDX_TX_STBL: begin
        rd_byte = tx_stabilize_ifs;
      end
      `RBMC_IDX_HR_EN: begin
        rd_byte = {7'h00, high_rate_enable};
      end
      `RBMC_IDX_PREAMBLE: begin
        rd_byte = {preamble_threshold, 1'b0};
      end
      `RBMC_IDX_CS: begin
        rd_byte = {carrier_sense_preamble, 2'h0};
      end
      `RBMC_IDX_FE_SEL: begin
        rd_byte = {3'h0, front_end_pin_select};
      end
      default: begin
        // Unmapped indices read as zero and answer with an error.
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write channel: take address and data separately, answer once both are in.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RBMC_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_idx <= 10'h000;
      wr_byte <= 8'h00;
      wr_lane0 <= 1'b0;
    end else begin
      // Ready is offered one cycle after valid so a held beat is never overwritten.
      s_axi_awready <= !aw_held && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_held && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_idx <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_byte <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      // The beat pair is retired and its response raised in the cycle of the store.
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RBMC_RESP_OKAY : `RBMC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage; only byte lane 0 carries data, the upper lanes are ignored.
  always @(posedge aclk) begin
    if (!aresetn) begin
      amp_on_time_high_and_tick <= `RBMC_RST_AMP_TICK;
      power_amp_on_time_low <= `RBMC_RST_PA_ON_LOW;
      power_amp_on_time_ctrl <= `RBMC_RST_PA_ON_CTRL;
      tx_on_time_ctrl <= `RBMC_RST_TX_ON_CTRL;
      tx_stabilize_ifs <= `RBMC_RST_TX_STBL;
      high_rate_enable <= `RBMC_RST_HR_EN;
      preamble_threshold <= `RBMC_RST_PREAMBLE;
      carrier_sense_preamble <= `RBMC_RST_CS;
      front_end_pin_select <= `RBMC_RST_FE_SEL;
      rst_start <= 3'h0;
    end else begin
      rst_start <= 3'h0;
      if (wr_fire && wr_lane0) begin
        case (wr_idx)
          `RBMC_IDX_AMP_TICK: begin
            amp_on_time_high_and_tick <= wr_byte;
          end
          `RBMC_IDX_PA_ON_LOW: begin
            power_amp_on_time_low <= wr_byte;
          end
          `RBMC_IDX_PA_ON_CTRL: begin
            power_amp_on_time_ctrl <= wr_byte[4:0];
          end
          `RBMC_IDX_TX_ON_CTRL: begin
            tx_on_time_ctrl <= {wr_byte[7], wr_byte[5:0]};
          end
          `RBMC_IDX_SOFT_RST: begin
            // Writing one starts a pulse; writing zero has no effect.
            rst_start <= wr_byte[2:0];
          end
          `RBMC_IDX_TX_STBL: begin
            tx_stabilize_ifs <= wr_byte;
          end
          `RBMC_IDX_HR_EN: begin
            high_rate_enable <= wr_byte[`RBMC_HR_EN_BIT];
          end
          `RBMC_IDX_PREAMBLE: begin
            // The host is expected to put 0011 here for high rate.
            preamble_threshold <= wr_byte[7:1];
          end
          `RBMC_IDX_CS: begin
            // The host is expected to put 010 here for high rate.
            carrier_sense_preamble <= wr_byte[7:2];
          end
          `RBMC_IDX_FE_SEL: begin
            front_end_pin_select <= wr_byte[4:0];
          end
          default: begin
            // Unmapped indices store nothing; the response already reports the error.
            rst_start <= 3'h0;
          end
        endcase
      end
    end
  end

  // Read channel: one read at a time, data one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RBMC_RESP_OKAY;
    end else begin
      // No address is taken while read data stands, so unread data is never overwritten.
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? `RBMC_RESP_OKAY : `RBMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Baseband-facing settings. The rate and thresholds take effect only when the
  // baseband reset completes, so the modem never switches rate inside a frame.
  always @(posedge aclk) begin
    if (!aresetn) begin
      high_rate_active <= 1'b0;
      over_air_rate_kbps <= `RBMC_RATE_NORMAL_KBPS;
      // The modem starts at the normal rate with every threshold cleared.
      preamble_valid_threshold <= `RBMC_RST_PV_THR;
      preamble_detect_threshold <= 3'h0;
      carrier_sense_threshold <= 3'h0;
      preamble_count <= 3'h0;
    end else if (rst_done[`RBMC_RST_BB_BIT]) begin
      high_rate_active <= high_rate_enable;
      if (high_rate_enable) begin
        over_air_rate_kbps <= `RBMC_RATE_HIGH_KBPS;
      end else begin
        over_air_rate_kbps <= `RBMC_RATE_NORMAL_KBPS;
      end
      preamble_valid_threshold <= preamble_threshold[6:3];
      preamble_detect_threshold <= preamble_threshold[2:0];
      carrier_sense_threshold <= carrier_sense_preamble[5:3];
      preamble_count <= carrier_sense_preamble[2:0];
    end
  end

  // Amplifier timing settings are copied from their registers through one flip-flop stage.
  always @(posedge aclk) begin
    if (!aresetn) begin
      power_amp_on_time <= 9'h000;
      tx_on_time <= 9'h000;
      rf_stabilize_time <= 4'h0;
      short_ifs_time <= 4'h0;
    end else begin
      // The extra stage keeps every output on a flip-flop, at one cycle of latency.
      power_amp_on_time <= {power_amp_on_time_ctrl[0], power_amp_on_time_low};
      tx_on_time <= {tx_on_time_ctrl[1:0], amp_on_time_high_and_tick[7:1]};
      rf_stabilize_time <= tx_stabilize_ifs[7:4];
      short_ifs_time <= tx_stabilize_ifs[3:0];
    end
  end

  // One pulse generator for each of the MAC, baseband and power block resets.
  genvar gi;
  // Each block has its own counter, so pulses for different blocks may overlap freely.
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_rst
      rbmc_soft_rst #(
        .CYCLES(RST_CYCLES),
        .CW(8)
      ) u_rst (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(rst_start[gi]),
        .busy(rst_busy[gi]),
        .done(rst_done[gi])
      );
    end
  endgenerate

  // Pin driver; external amplifier control only for the exact value 111.
  // Bits 4:3 of the select register are kept for software only and never reach the pins.
  rbmc_fe_pins u_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_amp_en(ext_amp_sel),
    .rf_tx_active(rf_tx_active),
    .gen_gpio_out(gen_gpio_out),
    .gen_gpio_oe(gen_gpio_oe),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe)
  );

endmodule

// ===== inc/rbmc_map.vh
// Register indices, field positions, reset values and timing counts of the mode config block.
`ifndef RBMC_MAP_VH
`define RBMC_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define RBMC_IDX_AMP_TICK 10'h015
`define RBMC_IDX_PA_ON_LOW 10'h016
`define RBMC_IDX_PA_ON_CTRL 10'h017
`define RBMC_IDX_TX_ON_CTRL 10'h018
`define RBMC_IDX_SOFT_RST 10'h02a
`define RBMC_IDX_TX_STBL 10'h02e
`define RBMC_IDX_HR_EN 10'h038
`define RBMC_IDX_PREAMBLE 10'h03b
`define RBMC_IDX_CS 10'h03c
`define RBMC_IDX_FE_SEL 10'h22f

// Field positions.
`define RBMC_HR_EN_BIT 0
`define RBMC_RST_MAC_BIT 0
`define RBMC_RST_BB_BIT 1
`define RBMC_RST_PWR_BIT 2
`define RBMC_FE_SEL_MSB 2
`define RBMC_FE_SEL_LSB 0
`define RBMC_FE_SEL_EXT 3'h7

// Over-the-air rates in kbps.
`define RBMC_RATE_NORMAL_KBPS 10'h0fa
`define RBMC_RATE_HIGH_KBPS 10'h271

// Reset values of the stored registers.
`define RBMC_RST_AMP_TICK 8'h00
`define RBMC_RST_PA_ON_LOW 8'h00
`define RBMC_RST_PA_ON_CTRL 5'h00
`define RBMC_RST_TX_ON_CTRL 7'h00
`define RBMC_RST_TX_STBL 8'h00
`define RBMC_RST_HR_EN 1'h0
`define RBMC_RST_PREAMBLE 7'h00
`define RBMC_RST_CS 6'h00
`define RBMC_RST_FE_SEL 5'h00
`define RBMC_RST_PV_THR 4'h0

// Timing of the soft reset pulses.
`define RBMC_CLK_PERIOD_NS 40
`define RBMC_SOFT_RST_NS 400
`define RBMC_SOFT_RST_CYC ((`RBMC_SOFT_RST_NS + `RBMC_CLK_PERIOD_NS - 1) / `RBMC_CLK_PERIOD_NS)

// Bus responses.
`define RBMC_RESP_OKAY 2'h0
`define RBMC_RESP_SLVERR 2'h2

`endif

// ===== rtl/rbmc_soft_rst.v
// Self-clearing soft reset pulse generator for one circuit block.
`timescale 1ns/1ps
module rbmc_soft_rst #(
  parameter CYCLES = 10,
  parameter CW = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  output reg busy,
  output reg done
);

  // Cycles left in the running reset pulse.
  reg [CW-1:0] count;

  // A start while busy is ignored; the pulse is never stretched by a repeat request.
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= {CW{1'b0}};
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          count <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
        end
      end else if (count == {CW{1'b0}}) begin
        // Release; the request bit then reads back as zero.
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        count <= count - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ===== rtl/rbmc_fe_pins.v
// Front-end pin driver: general purpose pins 0 to 2 or external amplifier control.
`timescale 1ns/1ps
module rbmc_fe_pins (
  input wire aclk,
  input wire aresetn,
  input wire ext_amp_en,
  input wire rf_tx_active,
  input wire [2:0] gen_gpio_out,
  input wire [2:0] gen_gpio_oe,
  output reg [2:0] gpio_out,
  output reg [2:0] gpio_oe
);

  // Pins are registered so the pads see clean levels with no decode glitches.
  always @(posedge aclk) begin
    if (!aresetn) begin
      gpio_out <= 3'h0;
      gpio_oe <= 3'h0;
    end else if (ext_amp_en) begin
      // Only the RF state machine steers the pins here; no register can.
      gpio_oe <= 3'h7;
      if (rf_tx_active) begin
        gpio_out <= 3'h3;
      end else begin
        // Idle is treated as receive so the low-noise path stays selected.
        gpio_out <= 3'h4;
      end
    end else begin
      gpio_out <= gen_gpio_out;
      gpio_oe <= gen_gpio_oe;
    end
  end

endmodule

// ===== test/rbmc_properties.sv
// Concurrent checks on the ports of the mode configuration block.
`timescale 1ns/1ps
module rbmc_props #(
  parameter RST_CYCLES = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire rf_tx_active,
  input wire [2:0] gen_gpio_oe,
  input wire [2:0] gpio_out,
  input wire [2:0] gpio_oe,
  input wire high_rate_active,
  input wire [9:0] over_air_rate_kbps,
  input wire baseband_reset
);
  // Cycles seen so far in the current baseband reset pulse.
  reg [7:0] run_len;
  // A counter avoids a long repetition that the tools would unroll.
  always @(posedge aclk) begin
    if (!aresetn || !baseband_reset) begin
      run_len <= 8'h00;
    end else begin
      run_len <= run_len + 8'h01;
    end
  end
  rate_follows_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    over_air_rate_kbps == (high_rate_active ? 10'h271 : 10'h0fa))
    else $error("Rate does not match the mode.");
  amp_pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && gpio_oe != $past(gen_gpio_oe) |->
    gpio_oe == 3'h7 && gpio_out == ($past(rf_tx_active) ? 3'h3 : 3'h4))
    else $error("Pins left normal drive without amplifier pattern.");
  bb_pulse_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(baseband_reset) |-> run_len == RST_CYCLES)
    else $error("Baseband reset pulse has the wrong length.");
  bb_pulse_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(baseband_reset) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("Baseband reset began without a write.");
  mode_at_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(high_rate_active) |->
    !baseband_reset && ($past(baseband_reset) || $past(baseband_reset, 2)))
    else $error("High rate changed outside a baseband reset end.");
  write_resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early.");
  read_data_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early.");
  read_upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Read data upper bits not zero.");
endmodule
bind rbmc_top rbmc_props #(.RST_CYCLES(RST_CYCLES)) i_props (.aclk, .aresetn,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .rf_tx_active, .gen_gpio_oe, .gpio_out, .gpio_oe, .high_rate_active,
  .over_air_rate_kbps, .baseband_reset);

// ===== test/rbmc_fe_model.sv
// Behavioural model of the external amplifiers and antenna switch on pins 0 to 2.
`timescale 1ns/1ps
module rbmc_fe_model (
  input wire [2:0] gpio_out,
  input wire [2:0] gpio_oe,
  output wire pa_on,
  output wire tx_switch,
  output wire lna_on
);
  // An undriven pin reads as off, since each control line has a pull-down.
  assign pa_on = gpio_oe[0] & gpio_out[0];
  assign tx_switch = gpio_oe[1] & gpio_out[1];
  assign lna_on = gpio_oe[2] & gpio_out[2];
endmodule

// ===== test/tb.sv
// Register and pin tests for the mode configuration block.
`timescale 1ns/1ps
module tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h000;
  reg [11:0] s_axi_araddr = 12'h000;
  reg [2:0] prot = 3'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg rf_tx_active = 1'b0;
  reg [2:0] gen_gpio_out = 3'h5;
  reg [2:0] gen_gpio_oe = 3'h2;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] gpio_out, gpio_oe, preamble_detect_threshold, carrier_sense_threshold;
  wire [2:0] preamble_count;
  wire [3:0] rf_stabilize_time, short_ifs_time;
  wire high_rate_active, baseband_reset, mac_reset, power_block_reset;
  wire pa_on, tx_switch, lna_on;
  wire [9:0] over_air_rate_kbps;
  wire [3:0] preamble_valid_threshold;
  wire [8:0] power_amp_on_time, tx_on_time;
  integer fails = 0;
  integer comparisons = 0;
  integer i;
  reg slow = 1'b0; // When set, bready and rready are held back for a few cycles.
  // Byte addresses and stored-bit masks of the register table.
  reg [11:0] ra [0:8] = '{12'h054, 12'h058, 12'h05c, 12'h060, 12'h0b8, 12'h0e0, 12'h0ec,
    12'h0f0, 12'h8bc};
  reg [7:0] rm [0:8] = '{8'hff, 8'hff, 8'h1f, 8'hbf, 8'hff, 8'h01, 8'hfe, 8'hfc, 8'h1f};
  rbmc_top #(.RST_CYCLES(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(prot),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(prot),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rf_tx_active, .gen_gpio_out, .gen_gpio_oe, .gpio_out, .gpio_oe, .high_rate_active,
    .over_air_rate_kbps, .baseband_reset, .mac_reset, .power_block_reset,
    .preamble_valid_threshold, .preamble_detect_threshold, .carrier_sense_threshold,
    .preamble_count, .power_amp_on_time, .tx_on_time, .rf_stabilize_time,
    .short_ifs_time);
  rbmc_fe_model i_fe (.gpio_out, .gpio_oe, .pa_on, .tx_switch, .lna_on);
  // The clock toggles every half period of 40 ns.
  initial forever #20 aclk = ~aclk;
  // Counts a comparison and reports a mismatch at once.
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task conclude;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  // One write; address and data are offered together and each is dropped once taken.
  task wr(input [11:0] a, input [7:0] d, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      for (n = 0; n < 60; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid && s_axi_bready) begin
          chk(s_axi_bresp, er);
          n = 99;
        end
        if (n == 4) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      if (n < 99) begin
        fails = fails + 1;
        conclude;
      end
    end
  endtask
  // One read; data and response are taken at the edge where rvalid and rready are both seen.
  task rd(input [11:0] a, input [7:0] ed, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      for (n = 0; n < 60; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid && s_axi_rready) begin
          chk(s_axi_rdata, {24'h000000, ed});
          chk(s_axi_rresp, er);
          n = 99;
        end
        if (n == 4) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      if (n < 99) begin
        fails = fails + 1;
        conclude;
      end
    end
  endtask
  // Waits, bounded, for the baseband reset pulse to end and its effects to land.
  task wait_bb;
    integer n;
    begin
      // The pulse starts one edge after the response, so look only after an edge.
      @(posedge aclk);
      for (n = 0; n < 60 && baseband_reset !== 1'b0; n = n + 1) @(posedge aclk);
      if (n == 60) begin
        fails = fails + 1;
        conclude;
      end
      repeat (2) @(posedge aclk);
    end
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk(over_air_rate_kbps, 32'h0fa);
    for (i = 0; i < 9; i = i + 1) begin
      rd(ra[i], 8'h00, 2'h0);
      wr(ra[i], 8'hff, 2'h0);
      rd(ra[i], rm[i], 2'h0);
    end
    chk({power_amp_on_time, tx_on_time}, 32'h3ffff);
    chk({rf_stabilize_time, short_ifs_time}, 32'hff);
    slow = 1'b1;
    s_axi_wstrb <= 4'h0;
    wr(12'h058, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h058, 8'hff, 2'h0);
    slow = 1'b0;
    wr(12'h004, 8'h12, 2'h2);
    rd(12'h004, 8'h00, 2'h2);
    chk(high_rate_active, 32'h0);
    wr(12'h0ec, 8'h3e, 2'h0);
    wr(12'h0f0, 8'h5c, 2'h0);
    wr(12'h0a8, 8'h02, 2'h0);
    rd(12'h0a8, 8'h02, 2'h0);
    wait_bb;
    chk({high_rate_active, over_air_rate_kbps}, {1'b1, 10'h271});
    chk({preamble_valid_threshold, carrier_sense_threshold}, 32'h1a);
    chk({preamble_detect_threshold, preamble_count}, 32'h3f);
    rd(12'h0a8, 8'h00, 2'h0);
    wr(12'h0e0, 8'h00, 2'h0);
    wr(12'h0a8, 8'h02, 2'h0);
    wait_bb;
    chk({high_rate_active, over_air_rate_kbps}, {1'b0, 10'h0fa});
    wr(12'h0a8, 8'h05, 2'h0);
    rd(12'h0a8, 8'h05, 2'h0);
    chk({power_block_reset, baseband_reset, mac_reset}, 32'h5);
    chk({gpio_oe, gpio_out, pa_on, tx_switch, lna_on}, 32'h1e1);
    rf_tx_active <= 1'b1;
    gen_gpio_out <= 3'h2;
    repeat (3) @(posedge aclk);
    chk({gpio_oe, gpio_out, pa_on, tx_switch, lna_on}, 32'h1de);
    wr(12'h8bc, 8'h06, 2'h0);
    repeat (3) @(posedge aclk);
    chk({gpio_oe, gpio_out}, 32'h12);
    conclude;
  end
endmodule
